//--- design/pmbus_consts.svh
// constants shared by both ends of the management link
// assumes one 40 MHz system clock on each end
`ifndef PMBUS_CONSTS_SVH
`define PMBUS_CONSTS_SVH

// link addressing and command codes
`define SLV_ADDR        7'h58
`define CMD_FAN1        8'h90
`define CMD_FAN2        8'h91
`define CMD_MAKER       8'h99
`define CMD_MODEL       8'h9A
`define CMD_SERIES      8'h9B
`define CMD_SERIAL      8'h9E
`define CMD_SUMMARY     8'hD0
`define CMD_UNIT        8'hD1
`define CMD_ALARM       8'hD2

// data byte counts
`define LEN_WORD        5'h02
`define LEN_MAKER       5'h06
`define LEN_MODEL       5'h10
`define LEN_SERIES      5'h08
`define LEN_SERIAL      5'h10
`define LEN_SUMMARY     5'h0B
`define LEN_ALARM       5'h03
`define CRC_POLY        8'h07

// field positions
`define SH_PEC          7
`define SH_INVAL        5
`define SH_ORTEST       3
`define A3_INTERLOCK    7
`define A3_ORING        0

// timing
`define CLK_PERIOD_NS   25
`define SCL_PERIOD_NS   400
`define SCL_HALF_CYC    5'(`SCL_PERIOD_NS / (2 * `CLK_PERIOD_NS))
`define SCL_QTR_CYC     5'(`SCL_PERIOD_NS / (4 * `CLK_PERIOD_NS))
`define SCL_LAST_CYC    5'(`SCL_PERIOD_NS / `CLK_PERIOD_NS - 1)

// host register map (apb byte addresses)
`define HOST_CTRL       8'h00
`define HOST_STATUS     8'h04
`define HOST_RXDATA     8'h08
`define CTRL_BLK        8
`define CTRL_GO         9

`endif

//--- design/pmbus_pkg.sv
// types and helpers shared by both ends
// assumes pmbus_consts.svh on the include path
`include "pmbus_consts.svh"
package pmbus_pkg;
	typedef enum logic [3:0] {
		D_IDLE  = 4'h0,
		D_ADDR  = 4'h1,
		D_AACK  = 4'h3,
		D_CMD   = 4'h2,
		D_CACK  = 4'h6,
		D_PECIN = 4'h7,
		D_PACK  = 4'h5,
		D_TX    = 4'h4,
		D_TACK  = 4'hC,
		D_IGN   = 4'hD
	} dev_state_t;

	typedef enum logic [2:0] {
		H_IDLE   = 3'h0,
		H_START  = 3'h1,
		H_WR     = 3'h3,
		H_RSTART = 3'h2,
		H_RD     = 3'h6,
		H_STOP   = 3'h7
	} host_state_t;

	// smbus packet error code, one byte step
	function automatic logic [7:0] crc8(input logic [7:0] c,
		input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) begin
			r = r[7] ? ({r[6:0], 1'b0} ^ `CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction
endpackage

//--- design/pmbus_if.sv
// two-wire management link between host and rectifier
// sda is open drain with pull-up: low while any end enables
interface pmbus_if;
	logic scl;
	logic hostSdaOe;
	logic devSdaOe;
	logic sda;

	assign sda = ~(hostSdaOe | devSdaOe);

	modport host (output scl, output hostSdaOe, input sda);
	modport dev (input scl, input sda, output devSdaOe);
endinterface

//--- design/pmbus_mfr_responder.sv
// rectifier end: vendor read-back slave with packet error code
// assumes scl and sda arrive unsynchronised from the link
//
// Behaviour
// - data bytes all ones when data not ready
// - fan commands return measured rpm, direct format
// - host fetches identity records one per read
// - maker record is at most six characters
// - model record is sixteen characters
// - series record eight bytes, null padded
// - serial record sixteen characters, date first
// - reads over two bytes use block read
// - block read starts with data byte count
// - analog values go low byte first
// - host nacks pec byte then stops
// - status, alarms readable together or grouped
// - summary order: status, alarms, volts, amps, temp
// - summary temperature is nearest to shutdown
// - unit status word, high byte first
// - or'ing flag set by host or self test
// - only destructive or'ing fault shuts down
// - host judges power capacity before test
// - write command, repeated start, read, pec
// - alarm-3 interlock bit 7, or'ing bit 0
//
// The implementer's own choices: register access over APB and the register offsets.
module pmbus_mfr_responder
	import pmbus_pkg::*;
#(
	// arbitrary neutral identity values
	parameter logic [47:0]  MAKER_ID  = "ABC-XY",
	parameter logic [127:0] MODEL_ID  = "MODEL-0000000000",
	parameter logic [63:0]  SERIES_ID = {"A:BC", 32'h0000_0000},
	parameter logic [127:0] SERIAL_ID = "24AB010000000001"
) (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// link
	pmbus_if.dev             bus,
	// monitored values
	input  wire logic [7:0]  statusHighIn,
	input  wire logic [7:0]  statusLowIn,
	input  wire logic [7:0]  alarm3In,
	input  wire logic [7:0]  alarm2In,
	input  wire logic [7:0]  alarm1In,
	input  wire logic [15:0] voltOut,
	input  wire logic [15:0] currOut,
	input  wire logic [15:0] tempA,
	input  wire logic [15:0] tempB,
	input  wire logic [15:0] tempAShut,
	input  wire logic [15:0] tempBShut,
	input  wire logic [15:0] fan1Rpm,
	input  wire logic [15:0] fan2Rpm,
	input  wire logic        dataReady,
	input  wire logic        interlockOpen,
	// or'ing test
	input  wire logic        orTestFail,
	input  wire logic        orSelfFail,
	input  wire logic        orDestructive,
	input  wire logic        orFaultClear,
	// flags out
	output logic             orFaultFlag,
	output logic             shutdownReq,
	output logic             pecErrFlag
);
	// ****************************************
	// input synchronisers
	// ****************************************
	logic [2:0] sclSy;
	logic [2:0] sdaSy;
	logic       sclF;
	logic       sdaF;
	logic       sclNew;
	logic       sdaNew;
	logic       sclRise;
	logic       sclFall;
	logic       startC;
	logic       stopC;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sclSy <= 3'h7;
			sdaSy <= 3'h7;
			sclF  <= 1'b1;
			sdaF  <= 1'b1;
		end else begin
			sclSy <= {sclSy[1:0], bus.scl};
			sdaSy <= {sdaSy[1:0], bus.sda};
			sclF  <= sclNew;
			sdaF  <= sdaNew;
		end
	end

	assign sclNew  = (sclSy[1] == sclSy[2]) ? sclSy[2] : sclF;
	assign sdaNew  = (sdaSy[1] == sdaSy[2]) ? sdaSy[2] : sdaF;
	assign sclRise = sclNew & ~sclF;
	assign sclFall = ~sclNew & sclF;
	assign startC  = sclF & sclNew & sdaF & ~sdaNew;
	assign stopC   = sclF & sclNew & ~sdaF & sdaNew;

	// ****************************************
	// byte selection
	// ****************************************
	dev_state_t   state;
	logic [3:0]   bitCnt;
	logic [7:0]   sh;
	logic [7:0]   txSh;
	logic [7:0]   cmdReg;
	logic [7:0]   crcReg;
	logic [4:0]   idx;
	logic         rdMode;
	logic         oeReg;
	logic         invalidFlag;
	logic [7:0]   snapSH;
	logic [7:0]   snapSL;
	logic [7:0]   snapA3;
	logic [7:0]   snapA2;
	logic [7:0]   snapA1;
	logic [15:0]  snapV;
	logic [15:0]  snapI;
	logic [15:0]  snapT;
	logic [15:0]  snapF1;
	logic [15:0]  snapF2;
	logic         snapOk;
	logic [127:0] sel;
	logic [4:0]   len;
	logic         blk;
	logic [4:0]   pos;
	logic [7:0]   byteOut;
	logic [15:0]  nearTemp;
	logic         addrHit;
	logic         readHit;
	logic         cmdTake;
	logic         pecTake;

	function automatic logic cmdKnown(input logic [7:0] c);
		case (c)
			`CMD_FAN1, `CMD_FAN2, `CMD_MAKER, `CMD_MODEL, `CMD_SERIES,
			`CMD_SERIAL, `CMD_SUMMARY, `CMD_UNIT, `CMD_ALARM: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction

	// smaller margin to its own threshold wins
	assign nearTemp = ((tempAShut - tempA) <= (tempBShut - tempB)) ?
		tempA : tempB;

	always_comb begin
		sel = '0;
		len = 5'h00;
		blk = 1'b0;
		case (cmdReg)
			`CMD_FAN1: begin
				sel[15:0] = {snapF1[7:0], snapF1[15:8]};
				len = `LEN_WORD;
			end
			`CMD_FAN2: begin
				sel[15:0] = {snapF2[7:0], snapF2[15:8]};
				len = `LEN_WORD;
			end
			`CMD_MAKER: begin
				sel[47:0] = MAKER_ID;
				len = `LEN_MAKER;
				blk = 1'b1;
			end
			`CMD_MODEL: begin
				sel = MODEL_ID;
				len = `LEN_MODEL;
				blk = 1'b1;
			end
			`CMD_SERIES: begin
				sel[63:0] = SERIES_ID;
				len = `LEN_SERIES;
				blk = 1'b1;
			end
			`CMD_SERIAL: begin
				sel = SERIAL_ID;
				len = `LEN_SERIAL;
				blk = 1'b1;
			end
			`CMD_SUMMARY: begin
				sel[87:0] = {snapSH, snapSL, snapA3, snapA2, snapA1,
					snapV[7:0], snapV[15:8], snapI[7:0], snapI[15:8],
					snapT[7:0], snapT[15:8]};
				len = `LEN_SUMMARY;
				blk = 1'b1;
			end
			`CMD_UNIT: begin
				sel[15:0] = {snapSH, snapSL};
				len = `LEN_WORD;
			end
			`CMD_ALARM: begin
				sel[23:0] = {snapA3, snapA2, snapA1};
				len = `LEN_ALARM;
				blk = 1'b1;
			end
			default: ;
		endcase
		pos = blk ? idx - 5'h01 : idx;
		if (len == 5'h00)
			byteOut = 8'hFF;
		else if (blk && idx == 5'h00)
			byteOut = {3'h0, len};
		else if (pos < len)
			byteOut = snapOk ? sel[8 * (len - 5'h01 - pos) +: 8] : 8'hFF;
		else if (pos == len)
			byteOut = crcReg;
		else
			byteOut = 8'hFF;
	end

	// ****************************************
	// link state machine
	// ****************************************
	assign addrHit = sclFall && state == D_ADDR && bitCnt == 4'h8 &&
		sh[7:1] == `SLV_ADDR;
	assign readHit = addrHit & sh[0];
	assign cmdTake = sclFall && state == D_CMD && bitCnt == 4'h8;
	assign pecTake = sclFall && state == D_PECIN && bitCnt == 4'h8;
	assign bus.devSdaOe = oeReg;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state  <= D_IDLE;
			bitCnt <= 4'h0;
			sh     <= 8'h00;
			txSh   <= 8'h00;
			cmdReg <= 8'h00;
			crcReg <= 8'h00;
			idx    <= 5'h00;
			rdMode <= 1'b0;
			oeReg  <= 1'b0;
		end else if (stopC) begin
			state  <= D_IDLE;
			oeReg  <= 1'b0;
			crcReg <= 8'h00;
		end else if (startC) begin
			state  <= D_ADDR;
			bitCnt <= 4'h0;
			oeReg  <= 1'b0;
		end else if (sclRise) begin
			case (state)
				D_ADDR, D_CMD, D_PECIN: begin
					if (bitCnt < 4'h8) begin
						sh     <= {sh[6:0], sdaF};
						bitCnt <= bitCnt + 4'h1;
					end
				end
				D_TX: bitCnt <= bitCnt + 4'h1;
				D_TACK: begin
					if (sdaF)
						state <= D_IGN;
					else
						idx <= idx + 5'h01;
				end
				default: ;
			endcase
		end else if (sclFall) begin
			case (state)
				D_ADDR: begin
					if (addrHit) begin
						oeReg  <= 1'b1;
						crcReg <= crc8(crcReg, sh);
						rdMode <= sh[0];
						idx    <= 5'h00;
						state  <= D_AACK;
					end else if (bitCnt == 4'h8) begin
						state <= D_IGN;
					end
				end
				D_AACK, D_TACK: begin
					bitCnt <= 4'h0;
					if (rdMode) begin
						txSh  <= byteOut;
						oeReg <= ~byteOut[7];
						state <= D_TX;
					end else begin
						oeReg <= 1'b0;
						state <= D_CMD;
					end
				end
				D_CMD: begin
					if (cmdTake) begin
						cmdReg <= sh;
						crcReg <= crc8(crcReg, sh);
						oeReg  <= 1'b1;
						state  <= D_CACK;
					end
				end
				D_CACK: begin
					oeReg  <= 1'b0;
					bitCnt <= 4'h0;
					state  <= D_PECIN;
				end
				D_PECIN: begin
					if (pecTake) begin
						oeReg <= 1'b1;
						state <= D_PACK;
					end
				end
				D_PACK: begin
					oeReg <= 1'b0;
					state <= D_IGN;
				end
				D_TX: begin
					if (bitCnt == 4'h8) begin
						oeReg  <= 1'b0;
						crcReg <= crc8(crcReg, txSh);
						state  <= D_TACK;
					end else begin
						oeReg <= ~txSh[3'h7 - bitCnt[2:0]];
					end
				end
				default: ;
			endcase
		end
	end

	// ****************************************
	// snapshot at read address
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			snapSH <= 8'h00;
			snapSL <= 8'h00;
			snapA3 <= 8'h00;
			snapA2 <= 8'h00;
			snapA1 <= 8'h00;
			snapV  <= 16'h0000;
			snapI  <= 16'h0000;
			snapT  <= 16'h0000;
			snapF1 <= 16'h0000;
			snapF2 <= 16'h0000;
			snapOk <= 1'b0;
		end else if (readHit) begin
			snapSH <= {pecErrFlag, statusHighIn[6], invalidFlag,
				statusHighIn[4], orFaultFlag, 1'b0, statusHighIn[1:0]};
			snapSL <= statusLowIn;
			snapA3 <= {interlockOpen, alarm3In[6:1], orFaultFlag};
			snapA2 <= alarm2In;
			snapA1 <= alarm1In;
			snapV  <= voltOut;
			snapI  <= currOut;
			snapT  <= nearTemp;
			snapF1 <= fan1Rpm;
			snapF2 <= fan2Rpm;
			snapOk <= dataReady;
		end
	end

	// ****************************************
	// sticky flags
	// ****************************************
	logic unitRead;
	logic orSet;

	assign unitRead = readHit && cmdReg == `CMD_UNIT;
	assign orSet    = orTestFail | orSelfFail;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pecErrFlag  <= 1'b0;
			invalidFlag <= 1'b0;
		end else begin
			// unit status read clears, a new error wins
			pecErrFlag  <= (pecErrFlag & ~unitRead) |
				(pecTake & (sh != crcReg));
			invalidFlag <= (invalidFlag & ~unitRead) |
				(cmdTake & ~cmdKnown(sh));
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			orFaultFlag <= 1'b0;
			shutdownReq <= 1'b0;
		end else begin
			orFaultFlag <= (orFaultFlag & ~orFaultClear) | orSet;
			shutdownReq <= (shutdownReq & ~orFaultClear) |
				(orSet & orDestructive);
		end
	end
endmodule

//--- design/pmbus_host_master.sv
// host end: apb-controlled master issuing vendor reads
// assumes one responder on the link, no clock stretching
module pmbus_host_master
	import pmbus_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// link
	pmbus_if.host            bus,
	// apb slave
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr
);
	host_state_t hState;
	logic [4:0]  cyc;
	logic [3:0]  bitN;
	logic [7:0]  wrSh;
	logic [7:0]  rdSh;
	logic [1:0]  wrPhase;
	logic [4:0]  rdNo;
	logic [4:0]  total;
	logic [7:0]  crc;
	logic [7:0]  cmdReg;
	logic        blkReg;
	logic        busy;
	logic        done;
	logic        nack;
	logic        pecErr;
	logic [4:0]  cnt;
	logic [7:0]  rxBuf [16];
	logic [3:0]  rdIdx;
	logic        sclReg;
	logic        oeReg;
	logic [2:0]  sdaSy;
	logic        sdaF;
	logic        apbAcc;
	logic        goPulse;
	logic        bitEnd;
	logic        last;

	assign bus.scl       = sclReg;
	assign bus.hostSdaOe = oeReg;
	assign apbAcc  = psel & penable & ~pready;
	assign goPulse = apbAcc & pwrite & ~busy & paddr == `HOST_CTRL &
		pwdata[`CTRL_GO];
	assign bitEnd  = cyc == `SCL_LAST_CYC;
	assign last    = rdNo == total - 5'h01;

	// ****************************************
	// apb registers
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			cmdReg  <= 8'h00;
			blkReg  <= 1'b0;
			rdIdx   <= 4'h0;
		end else begin
			pready  <= apbAcc;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			if (apbAcc) begin
				case (paddr)
					`HOST_CTRL: begin
						if (pwrite && !busy) begin
							cmdReg <= pwdata[7:0];
							blkReg <= pwdata[`CTRL_BLK];
						end
						prdata <= {23'h0, blkReg, cmdReg};
					end
					`HOST_STATUS: prdata <= {23'h0, cnt, pecErr, nack, done, busy};
					`HOST_RXDATA: begin
						if (!pwrite) begin
							prdata <= {24'h0, rxBuf[rdIdx]};
							rdIdx  <= rdIdx + 4'h1;
						end
					end
					default: pslverr <= 1'b1;
				endcase
			end
			if (goPulse)
				rdIdx <= 4'h0;
		end
	end

	// ****************************************
	// sda input synchroniser
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sdaSy <= 3'h7;
			sdaF  <= 1'b1;
		end else begin
			sdaSy <= {sdaSy[1:0], bus.sda};
			if (sdaSy[1] == sdaSy[2])
				sdaF <= sdaSy[2];
		end
	end

	// ****************************************
	// link sequencer
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			hState  <= H_IDLE;
			cyc     <= 5'h00;
			bitN    <= 4'h0;
			wrSh    <= 8'h00;
			rdSh    <= 8'h00;
			wrPhase <= 2'h0;
			rdNo    <= 5'h00;
			total   <= 5'h00;
			crc     <= 8'h00;
			busy    <= 1'b0;
			done    <= 1'b0;
			nack    <= 1'b0;
			pecErr  <= 1'b0;
			cnt     <= 5'h00;
			sclReg  <= 1'b1;
			oeReg   <= 1'b0;
		end else if (hState == H_IDLE) begin
			sclReg <= 1'b1;
			oeReg  <= 1'b0;
			if (goPulse) begin
				hState  <= H_START;
				cyc     <= 5'h00;
				busy    <= 1'b1;
				done    <= 1'b0;
				nack    <= 1'b0;
				pecErr  <= 1'b0;
				cnt     <= 5'h00;
				crc     <= 8'h00;
				wrPhase <= 2'h0;
				// block length is known only after its count byte
				total   <= pwdata[`CTRL_BLK] ? 5'h1F : 5'h03;
			end
		end else begin
			cyc    <= bitEnd ? 5'h00 : cyc + 5'h01;
			sclReg <= (hState == H_START) || cyc >= `SCL_HALF_CYC;
			case (hState)
				H_START: begin
					if (cyc == `SCL_HALF_CYC)
						oeReg <= 1'b1;
					if (bitEnd) begin
						hState <= H_WR;
						wrSh   <= {`SLV_ADDR, 1'b0};
						bitN   <= 4'h0;
					end
				end
				H_WR: begin
					// sda moves mid-low so no false start or stop
					if (cyc == `SCL_QTR_CYC)
						oeReg <= (bitN == 4'h8) ? 1'b0 : ~wrSh[3'h7 - bitN[2:0]];
					if (cyc == `SCL_HALF_CYC + `SCL_QTR_CYC && bitN == 4'h8)
						nack <= nack | sdaF;
					if (bitEnd) begin
						bitN <= bitN + 4'h1;
						if (bitN == 4'h8) begin
							bitN <= 4'h0;
							crc  <= crc8(crc, wrSh);
							if (nack) begin
								hState <= H_STOP;
							end else if (wrPhase == 2'h0) begin
								wrSh    <= cmdReg;
								wrPhase <= 2'h1;
							end else if (wrPhase == 2'h1) begin
								hState <= H_RSTART;
							end else begin
								hState <= H_RD;
								rdNo   <= 5'h00;
							end
						end
					end
				end
				H_RSTART: begin
					if (cyc == `SCL_QTR_CYC)
						oeReg <= 1'b0;
					if (cyc == `SCL_HALF_CYC + `SCL_QTR_CYC)
						oeReg <= 1'b1;
					if (bitEnd) begin
						hState  <= H_WR;
						wrSh    <= {`SLV_ADDR, 1'b1};
						wrPhase <= 2'h2;
						bitN    <= 4'h0;
					end
				end
				H_RD: begin
					if (cyc == `SCL_QTR_CYC)
						oeReg <= (bitN == 4'h8) & ~last;
					if (cyc == `SCL_HALF_CYC + `SCL_QTR_CYC && bitN != 4'h8)
						rdSh <= {rdSh[6:0], sdaF};
					if (bitEnd) begin
						bitN <= bitN + 4'h1;
						if (bitN == 4'h8) begin
							bitN <= 4'h0;
							rdNo <= rdNo + 5'h01;
							if (last) begin
								pecErr <= rdSh != crc;
								hState <= H_STOP;
							end else begin
								crc <= crc8(crc, rdSh);
								if (blkReg && rdNo == 5'h00) begin
									total <= rdSh[4:0] + 5'h02;
								end else if (cnt < 5'h10) begin
									rxBuf[cnt[3:0]] <= rdSh;
									cnt <= cnt + 5'h01;
								end
							end
						end
					end
				end
				H_STOP: begin
					if (cyc == `SCL_QTR_CYC)
						oeReg <= 1'b1;
					if (cyc == `SCL_HALF_CYC + `SCL_QTR_CYC)
						oeReg <= 1'b0;
					if (bitEnd) begin
						hState <= H_IDLE;
						busy   <= 1'b0;
						done   <= 1'b1;
					end
				end
				default: hState <= H_IDLE;
			endcase
		end
	end
endmodule

//--- testbench/pmbus_link_properties.sv
// link and or'ing-flag properties for the host/rectifier pair
// assumes instantiation beside the link interface in testbench
module pmbus_link_properties (
	// clock and reset
	input logic sys_clk,
	input logic srst,
	// link
	input logic scl,
	input logic hostSdaOe,
	input logic devSdaOe,
	input logic sda,
	// or'ing test
	input logic orTestFail,
	input logic orSelfFail,
	input logic orDestructive,
	input logic orFaultClear,
	input logic orFaultFlag,
	input logic shutdownReq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// ****************************************
	// or'ing fault flag and shutdown
	// ****************************************
	property p_or_set;
		orTestFail || orSelfFail |=> orFaultFlag;
	endproperty
	a_or_set: assert property (p_or_set)
		else $error("or'ing event did not set the fault flag");
	property p_or_hold;
		orFaultFlag && !orFaultClear |=> orFaultFlag;
	endproperty
	a_or_hold: assert property (p_or_hold)
		else $error("or'ing fault flag dropped without clear");
	property p_or_clear;
		orFaultClear && !orTestFail && !orSelfFail
			|=> !orFaultFlag && !shutdownReq;
	endproperty
	a_or_clear: assert property (p_or_clear)
		else $error("clear left or'ing flags set");
	property p_destr_shut;
		(orTestFail || orSelfFail) && orDestructive |=> shutdownReq;
	endproperty
	a_destr_shut: assert property (p_destr_shut)
		else $error("destructive fault without shutdown");
	property p_nondestr;
		!shutdownReq && !((orTestFail || orSelfFail) && orDestructive)
			|=> !shutdownReq;
	endproperty
	a_nondestr: assert property (p_nondestr)
		else $error("shutdown without destructive fault");
	property p_shut_flag;
		shutdownReq |-> orFaultFlag;
	endproperty
	a_shut_flag: assert property (p_shut_flag)
		else $error("shutdown without or'ing fault flag");

	// ****************************************
	// link timing
	// ****************************************
	property p_dev_change;
		$changed(devSdaOe) |-> !scl;
	endproperty
	a_dev_change: assert property (p_dev_change)
		else $error("device changed sda while clock high");
	property p_scl_high;
		$rose(scl) |-> scl [*4];
	endproperty
	a_scl_high: assert property (p_scl_high)
		else $error("link clock high phase too short");
	property p_scl_low;
		$fell(scl) |=> !scl ##1 !scl ##1 !scl;
	endproperty
	a_scl_low: assert property (p_scl_low)
		else $error("link clock low phase too short");
endmodule

//--- testbench/testbench.sv
// bench: apb reads through the host end against the rectifier end
// assumes pmbus_consts.svh on the include path
`include "pmbus_consts.svh"
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary neutral identity strings
	localparam logic [47:0]  MAKER  = "QRS-UV";
	localparam logic [127:0] MODEL  = "TESTMODEL-000042";
	localparam logic [63:0]  SERIES = {"B:CD", 32'h0000_0000};
	localparam logic [127:0] SERIAL = "23QZ07000000A123";
	logic        sys_clk, srst, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, statusHighIn, statusLowIn;
	logic [7:0]  alarm3In, alarm2In, alarm1In;
	logic [31:0] pwdata, prdata;
	logic [15:0] voltOut, currOut, tempA, tempB, tempAShut, tempBShut;
	logic [15:0] fan1Rpm, fan2Rpm;
	logic        dataReady, interlockOpen, orTestFail, orSelfFail;
	logic        orDestructive, orFaultClear;
	logic        orFaultFlag, shutdownReq, pecErrFlag;
	int          err_total, checked;

	pmbus_if link();
	pmbus_host_master u_pmbus_host_master (.sys_clk(sys_clk), .srst(srst),
		.bus(link), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	pmbus_mfr_responder #(.MAKER_ID(MAKER), .MODEL_ID(MODEL),
		.SERIES_ID(SERIES), .SERIAL_ID(SERIAL)) u_pmbus_mfr_responder (
		.sys_clk(sys_clk), .srst(srst), .bus(link),
		.statusHighIn(statusHighIn), .statusLowIn(statusLowIn),
		.alarm3In(alarm3In), .alarm2In(alarm2In), .alarm1In(alarm1In),
		.voltOut(voltOut), .currOut(currOut), .tempA(tempA), .tempB(tempB),
		.tempAShut(tempAShut), .tempBShut(tempBShut), .fan1Rpm(fan1Rpm),
		.fan2Rpm(fan2Rpm), .dataReady(dataReady),
		.interlockOpen(interlockOpen), .orTestFail(orTestFail),
		.orSelfFail(orSelfFail), .orDestructive(orDestructive),
		.orFaultClear(orFaultClear), .orFaultFlag(orFaultFlag),
		.shutdownReq(shutdownReq), .pecErrFlag(pecErrFlag));
	pmbus_link_properties u_props (.sys_clk(sys_clk), .srst(srst),
		.scl(link.scl), .hostSdaOe(link.hostSdaOe),
		.devSdaOe(link.devSdaOe), .sda(link.sda),
		.orTestFail(orTestFail), .orSelfFail(orSelfFail),
		.orDestructive(orDestructive), .orFaultClear(orFaultClear),
		.orFaultFlag(orFaultFlag), .shutdownReq(shutdownReq));

	// ****************************************
	// compare, bus and verdict tasks
	// ****************************************
	task cmp_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			err_total++;
			$display("mismatch %s expected %0h seen %0h", nm, ex, got);
		end
	endtask
	task cmp_bit(input string nm, input logic ex, input logic got);
		checked++;
		if (got !== ex) begin
			err_total++;
			$display("mismatch %s expected %0b seen %0b", nm, ex, got);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= wr;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// only the watchdog ends a wait for the answer
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one transfer, then status and every stored byte
	task rd(input logic [7:0] cmd, input logic blk, input int n,
		input logic [127:0] v);
		logic [31:0] q;
		logic        e;
		apb(1'b1, `HOST_CTRL, {22'h0, 1'b1, blk, cmd}, q, e);
		do begin
			apb(1'b0, `HOST_STATUS, 32'h0, q, e);
		end while (q[1:0] !== 2'b10);
		cmp_val("status", 32'h2 | (32'(n) << 4), 32'(q[8:0]));
		for (int i = 0; i < n; i++) begin
			apb(1'b0, `HOST_RXDATA, 32'h0, q, e);
			cmp_val("byte", 32'(v[8*(n-1-i) +: 8]), 32'(q[7:0]));
		end
	endtask
	task pulse(input logic t, input logic s, input logic d, input logic c);
		@(posedge sys_clk);
		orTestFail <= t;
		orSelfFail <= s;
		orDestructive <= d;
		orFaultClear <= c;
		@(posedge sys_clk);
		{orTestFail, orSelfFail, orDestructive, orFaultClear} <= 4'h0;
		@(posedge sys_clk);
	endtask
	function automatic logic [7:0] sh(input logic f);
		return (statusHighIn & 8'h53) | {4'h0, f, 3'h0};
	endfunction
	function automatic logic [7:0] a3(input logic f);
		return {interlockOpen, alarm3In[6:1], f};
	endfunction
	function automatic logic [87:0] summary(input logic f);
		logic [15:0] t;
		// sensor b sits 8 below its limit, sensor a 32
		t = tempB;
		return {sh(f), statusLowIn, a3(f), alarm2In, alarm1In, voltOut[7:0],
			voltOut[15:8], currOut[7:0], currOut[15:8], t[7:0], t[15:8]};
	endfunction

	// ****************************************
	// clock, watchdog and main sequence
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (80000) @(posedge sys_clk);
		err_total++;
		give_verdict;
	end
	initial begin
		logic [31:0] q;
		logic        e;
		{srst, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
		{statusHighIn, statusLowIn} = 16'hFF5A;
		{alarm3In, alarm2In, alarm1In} = 24'hFFC33C;
		{voltOut, currOut} = 32'h1234_5678;
		{tempA, tempAShut, tempB, tempBShut} = 64'h0030_0050_0040_0048;
		{fan1Rpm, fan2Rpm} = 32'h0ABC_0DEF;
		{dataReady, interlockOpen} = 2'b11;
		{orTestFail, orSelfFail, orDestructive, orFaultClear} = 4'h0;
		repeat (12) @(posedge sys_clk);
		srst <= 1'b0;
		apb(1'b0, 8'h0C, 32'h0, q, e);
		cmp_bit("pslverr", 1'b1, e);
		cmp_val("prdata", 32'h0, q);
		rd(`CMD_FAN1, 1'b0, 2, 128'({fan1Rpm[7:0], fan1Rpm[15:8]}));
		rd(`CMD_FAN2, 1'b0, 2, 128'({fan2Rpm[7:0], fan2Rpm[15:8]}));
		rd(`CMD_MAKER, 1'b1, 6, 128'(MAKER));
		rd(`CMD_MODEL, 1'b1, 16, MODEL);
		rd(`CMD_SERIES, 1'b1, 8, 128'(SERIES));
		rd(`CMD_SERIAL, 1'b1, 16, SERIAL);
		rd(`CMD_SUMMARY, 1'b1, 11, 128'(summary(1'b0)));
		// unsupported code: ones back, invalid bit shows in unit status
		apb(1'b1, `HOST_CTRL, 32'h0000_02E5, q, e);
		do begin
			apb(1'b0, `HOST_STATUS, 32'h0, q, e);
		end while (q[1:0] !== 2'b10);
		cmp_val("unsupported", 32'h22, 32'(q[8:0] & 9'h1F7));
		apb(1'b0, `HOST_RXDATA, 32'h0, q, e);
		cmp_val("unsupported", 32'hFF, 32'(q[7:0]));
		rd(`CMD_UNIT, 1'b0, 2,
			128'({sh(1'b0) | 8'h20, statusLowIn}));
		pulse(1'b1, 1'b0, 1'b0, 1'b0);
		cmp_bit("orFaultFlag", 1'b1, orFaultFlag);
		cmp_bit("shutdownReq", 1'b0, shutdownReq);
		rd(`CMD_ALARM, 1'b1, 3, 128'({a3(1'b1), alarm2In, alarm1In}));
		rd(`CMD_UNIT, 1'b0, 2, 128'({sh(1'b1), statusLowIn}));
		pulse(1'b0, 1'b1, 1'b1, 1'b0);
		cmp_bit("shutdownReq", 1'b1, shutdownReq);
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		cmp_bit("orFaultFlag", 1'b0, orFaultFlag);
		cmp_bit("shutdownReq", 1'b0, shutdownReq);
		interlockOpen <= 1'b0;
		@(posedge sys_clk);
		rd(`CMD_SUMMARY, 1'b1, 11, 128'(summary(1'b0)));
		dataReady <= 1'b0;
		rd(`CMD_SUMMARY, 1'b1, 11, {128{1'b1}});
		cmp_bit("pecErrFlag", 1'b0, pecErrFlag);
		give_verdict;
	end
endmodule
